// ===== common/igcs_pkg.sv
// package: register map, field positions and reset values of the interrupt gating block
package igcs_pkg;
  // register byte addresses (word aligned)
  localparam logic [5:0] ADDR_INT_CTRL   = 6'h00;
  localparam logic [5:0] ADDR_PEN_ONE    = 6'h04;
  localparam logic [5:0] ADDR_PEN_TWO    = 6'h08;
  localparam logic [5:0] ADDR_PEN_THREE  = 6'h0C;
  localparam logic [5:0] ADDR_SHD_WREG   = 6'h10;
  localparam logic [5:0] ADDR_SHD_STATUS = 6'h14;
  localparam logic [5:0] ADDR_SHD_BANK   = 6'h18;
  localparam logic [5:0] ADDR_SHD_PTR0L  = 6'h1C;
  localparam logic [5:0] ADDR_SHD_PTR0H  = 6'h20;
  localparam logic [5:0] ADDR_SHD_PTR1L  = 6'h24;
  localparam logic [5:0] ADDR_SHD_PTR1H  = 6'h28;
  localparam logic [5:0] ADDR_SHD_PAGE   = 6'h2C;
  localparam logic [5:0] ADDR_OPTION     = 6'h30;
  localparam logic [5:0] ADDR_PIN_CHANGE = 6'h34;
  // interrupt control field positions
  localparam int BIT_GLB  = 7;
  localparam int BIT_PERI = 6;
  localparam int BIT_T0IE = 5;
  localparam int BIT_EXIE = 4;
  localparam int BIT_PCIE = 3;
  localparam int BIT_T0IF = 2;
  localparam int BIT_EXIF = 1;
  localparam int BIT_PCIF = 0;
  // status bits that are never shadowed (timeout, power-down)
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;
  // implemented bits of peripheral enable three
  localparam logic [7:0] PEN_THREE_MASK = 8'h7A;
  // reset values
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PEN      = 8'h00;
  // ext edge select position in option register
  localparam int BIT_EDGE = 6;
  // number of shadowed bytes
  localparam int SHD_COUNT = 8;
endpackage

// ===== core/igcs_edge_sync.sv
// pin synchroniser with edge detect for the external interrupt pin
`timescale 1ns/10ps
`default_nettype none
module igcs_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // pin and edge choice
  input  wire logic pin,
  input  wire logic rising,
  // detected edge pulse
  output logic      edge_pulse
);
  logic [2:0] sync_q;  // three stage chain
  logic [2:0] sync_d;
  logic       lvl_q;   // last accepted level
  logic       lvl_d;
  logic       pulse_d;

  // accept a change only when stages two and three agree
  always_comb begin
    sync_d  = {sync_q[1:0], pin};
    lvl_d   = lvl_q;
    pulse_d = 1'b0;
    if (sync_q[1] == sync_q[2] && sync_q[2] != lvl_q) begin
      lvl_d   = sync_q[2];
      pulse_d = (sync_q[2] == rising);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_q     <= 3'h0;
      lvl_q      <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      sync_q     <= sync_d;
      lvl_q      <= lvl_d;
      edge_pulse <= pulse_d;
    end
  end
endmodule
`default_nettype wire

// ===== core/igcs_core.sv
// interrupt gating, control registers and automatic context shadow
// Notes on behaviour
// - push return pc when interrupt taken
// - copy context registers into shadows on entry
// - restore context from shadows on return
// - shadows are software readable and writable
// - flags set regardless of any enable
// - global enable bit 7 gates everything
// - peripheral enable bit 6 gates peripheral sources
// - timer0 enable bit 5, flag bit 2
// - external pin enable bit 4, flag bit 1
// - pin-change enable bit 3, summary flag bit 0
// - summary flag read-only, follows port change flags
// - control register holds enables and flags
// - peripheral enable one holds eight enables
// - peripheral enable two holds eight enables
// - enable three bits 7,2,0 read zero
// - taking interrupt flushes, clears global, vectors
// - return pops, restores, sets global enable
// - external edge chosen by edge select
// - entry latency three to five instruction cycles
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module igcs_core #(
  parameter int PC_W = 15  // program counter width
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // avalon-mm register slave
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // event sources
  input  wire logic             timer0_ovf_evt,
  input  wire logic             ext_pin,
  input  wire logic [7:0]       port_change_flags,
  input  wire logic [7:0]       periph_flags_one,
  input  wire logic [7:0]       periph_flags_two,
  input  wire logic [7:0]       periph_flags_three,
  // core handshake
  input  wire logic             core_irq_ack,
  input  wire logic             core_return_from_irq,
  input  wire logic [PC_W-1:0]  core_pc,
  input  wire logic [63:0]      core_context,
  // core outputs
  output logic                  irq_request,
  output logic                  flush_prefetch,
  output logic                  stack_push,
  output logic [PC_W-1:0]       stack_push_pc,
  output logic                  stack_pop,
  output logic                  ctx_restore,
  output logic [63:0]           ctx_restore_data,
  output logic                  global_irq_enable
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]      ctrl_q, ctrl_d;         // enables and latched flags
  logic [7:0]      pen1_q, pen1_d;
  logic [7:0]      pen2_q, pen2_d;
  logic [7:0]      pen3_q, pen3_d;
  logic [7:0]      opt_q, opt_d;           // edge select lives here
  logic [7:0]      shd_q [igcs_pkg::SHD_COUNT];
  logic [7:0]      shd_d [igcs_pkg::SHD_COUNT];
  logic            wait_q, wait_d;         // bus wait flag, low in the answer cycle
  logic [31:0]     rdata_q, rdata_d;
  logic            req_q, req_d;
  logic            flush_q, flush_d;
  logic            push_q, push_d;
  logic [PC_W-1:0] ppc_q, ppc_d;
  logic            pop_q, pop_d;
  logic            rst_q, rst_d;
  logic [63:0]     rdat_q, rdat_d;
  logic            ext_edge;               // synchronised edge pulse
  logic            pc_flag;                // live pin-change summary
  logic            periph_hit;
  logic            core_hit;
  logic            wr_hit;
  logic            rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // external pin edge detector
  igcs_edge_sync u_edge (
    .clk        (clk),
    .rstn       (rstn),
    .pin        (ext_pin),
    .rising     (opt_q[igcs_pkg::BIT_EDGE]),
    .edge_pulse (ext_edge)
  );

  //////////////////////////////////////////////////////////////////////////////
  // source gating
  always_comb begin
    pc_flag    = |port_change_flags;
    periph_hit = |(periph_flags_one & pen1_q)
               | |(periph_flags_two & pen2_q)
               | |(periph_flags_three & pen3_q);
    core_hit   = (ctrl_q[igcs_pkg::BIT_T0IE] & ctrl_q[igcs_pkg::BIT_T0IF])
               | (ctrl_q[igcs_pkg::BIT_EXIE] & ctrl_q[igcs_pkg::BIT_EXIF])
               | (ctrl_q[igcs_pkg::BIT_PCIE] & pc_flag);
    wr_hit     = avs_write & ~avs_waitrequest;  // store at the edge the master sees the answer
    rd_hit     = avs_read & avs_waitrequest;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, bus, entry and return sequencing
  always_comb begin
    ctrl_d  = ctrl_q;
    pen1_d  = pen1_q;
    pen2_d  = pen2_q;
    pen3_d  = pen3_q;
    opt_d   = opt_q;
    shd_d   = shd_q;
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    flush_d = 1'b0;
    push_d  = 1'b0;
    ppc_d   = ppc_q;
    pop_d   = 1'b0;
    rst_d   = 1'b0;
    rdat_d  = rdat_q;
    // software writes go first so that hardware sets below win
    if (wr_hit && avs_byteenable[0]) begin
      unique case (avs_address)
        igcs_pkg::ADDR_INT_CTRL:   ctrl_d = {avs_writedata[7:1], 1'b0};
        igcs_pkg::ADDR_PEN_ONE:    pen1_d = avs_writedata[7:0];
        igcs_pkg::ADDR_PEN_TWO:    pen2_d = avs_writedata[7:0];
        igcs_pkg::ADDR_PEN_THREE:  pen3_d = avs_writedata[7:0] & igcs_pkg::PEN_THREE_MASK;
        igcs_pkg::ADDR_OPTION:     opt_d  = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_WREG:   shd_d[0] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_STATUS: shd_d[1] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_BANK:   shd_d[2] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_PTR0L:  shd_d[3] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_PTR0H:  shd_d[4] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_PTR1L:  shd_d[5] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_PTR1H:  shd_d[6] = avs_writedata[7:0];
        igcs_pkg::ADDR_SHD_PAGE:   shd_d[7] = avs_writedata[7:0];
        default: ;                                // unmapped writes are dropped
      endcase
    end
    // summary flag mirrors the port flags, never stored by software
    ctrl_d[igcs_pkg::BIT_PCIF] = pc_flag;
    // event sets beat a same-cycle software clear, independent of enables
    if (timer0_ovf_evt) ctrl_d[igcs_pkg::BIT_T0IF] = 1'b1;
    if (ext_edge)       ctrl_d[igcs_pkg::BIT_EXIF] = 1'b1;
    // entry: push pc and snapshot context in the same cycle
    if (core_irq_ack && req_q) begin
      ctrl_d[igcs_pkg::BIT_GLB] = 1'b0;
      flush_d = 1'b1;
      push_d  = 1'b1;
      ppc_d   = core_pc;
      for (int i = 0; i < igcs_pkg::SHD_COUNT; i++) begin
        shd_d[i] = core_context[i*8 +: 8];
      end
      // timeout and power-down bits keep their old shadow value, not taken from the context
      shd_d[1] = (core_context[15:8] & ~igcs_pkg::STATUS_KEEP_MASK)
               | (shd_q[1] & igcs_pkg::STATUS_KEEP_MASK);
    end else if (core_return_from_irq) begin
      ctrl_d[igcs_pkg::BIT_GLB] = 1'b1;
      pop_d   = 1'b1;
      rst_d   = 1'b1;
      for (int i = 0; i < igcs_pkg::SHD_COUNT; i++) begin
        rdat_d[i*8 +: 8] = shd_q[i];
      end
    end
    // read path, one wait state then answer
    if (rd_hit) begin
      unique case (avs_address)
        igcs_pkg::ADDR_INT_CTRL:   rdata_d = {24'h000000, ctrl_q};
        igcs_pkg::ADDR_PEN_ONE:    rdata_d = {24'h000000, pen1_q};
        igcs_pkg::ADDR_PEN_TWO:    rdata_d = {24'h000000, pen2_q};
        igcs_pkg::ADDR_PEN_THREE:  rdata_d = {24'h000000, pen3_q};
        igcs_pkg::ADDR_OPTION:     rdata_d = {24'h000000, opt_q};
        igcs_pkg::ADDR_SHD_WREG:   rdata_d = {24'h000000, shd_q[0]};
        igcs_pkg::ADDR_SHD_STATUS: rdata_d = {24'h000000, shd_q[1]};
        igcs_pkg::ADDR_SHD_BANK:   rdata_d = {24'h000000, shd_q[2]};
        igcs_pkg::ADDR_SHD_PTR0L:  rdata_d = {24'h000000, shd_q[3]};
        igcs_pkg::ADDR_SHD_PTR0H:  rdata_d = {24'h000000, shd_q[4]};
        igcs_pkg::ADDR_SHD_PTR1L:  rdata_d = {24'h000000, shd_q[5]};
        igcs_pkg::ADDR_SHD_PTR1H:  rdata_d = {24'h000000, shd_q[6]};
        igcs_pkg::ADDR_SHD_PAGE:   rdata_d = {24'h000000, shd_q[7]};
        igcs_pkg::ADDR_PIN_CHANGE: rdata_d = {24'h000000, port_change_flags};
        default:                   rdata_d = 32'h00000000;   // unmapped reads zero
      endcase
    end
    // answer one cycle after any request; kept in a flop so waitrequest has no gate
    wait_d = ~((avs_read | avs_write) & wait_q);
    // request uses the post-update global enable so clearing global stops it at once
    req_d = ctrl_d[igcs_pkg::BIT_GLB] & ~(core_irq_ack & req_q)
          & (core_hit | (ctrl_q[igcs_pkg::BIT_PERI] & periph_hit));
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= igcs_pkg::RST_INT_CTRL;
      pen1_q  <= igcs_pkg::RST_PEN;
      pen2_q  <= igcs_pkg::RST_PEN;
      pen3_q  <= igcs_pkg::RST_PEN;
      opt_q   <= 8'h00;
      for (int i = 0; i < igcs_pkg::SHD_COUNT; i++) begin
        shd_q[i] <= 8'h00;
      end
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      req_q   <= 1'b0;
      flush_q <= 1'b0;
      push_q  <= 1'b0;
      ppc_q   <= '0;
      pop_q   <= 1'b0;
      rst_q   <= 1'b0;
      rdat_q  <= 64'h0000000000000000;
    end else begin
      ctrl_q  <= ctrl_d;
      pen1_q  <= pen1_d;
      pen2_q  <= pen2_d;
      pen3_q  <= pen3_d;
      opt_q   <= opt_d;
      shd_q   <= shd_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      req_q   <= req_d;
      flush_q <= flush_d;
      push_q  <= push_d;
      ppc_q   <= ppc_d;
      pop_q   <= pop_d;
      rst_q   <= rst_d;
      rdat_q  <= rdat_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops; the core adds the instruction-cycle latency
  always_comb begin
    avs_waitrequest   = wait_q;
    avs_readdata      = rdata_q;
    irq_request       = req_q;
    flush_prefetch    = flush_q;
    stack_push        = push_q;
    stack_push_pc     = ppc_q;
    stack_pop         = pop_q;
    ctx_restore       = rst_q;
    ctx_restore_data  = rdat_q;
    global_irq_enable = ctrl_q[igcs_pkg::BIT_GLB];
  end
endmodule
`default_nettype wire

// ===== verification/igcs_props.sv
// checker: entry, return and bus handshake of the interrupt gating block
`timescale 1ns/10ps
`default_nettype none
module igcs_props #(
  parameter int PC_W = 15  // program counter width
) (
  // clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // register bus
  input wire logic            avs_read,
  input wire logic            avs_write,
  input wire logic            avs_waitrequest,
  // core handshake
  input wire logic            core_irq_ack,
  input wire logic            core_return_from_irq,
  input wire logic [PC_W-1:0] core_pc,
  // block outputs
  input wire logic            irq_request,
  input wire logic            flush_prefetch,
  input wire logic            stack_push,
  input wire logic [PC_W-1:0] stack_push_pc,
  input wire logic            stack_pop,
  input wire logic            ctx_restore,
  input wire logic            global_irq_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_push_on_ack: assert property (
    core_irq_ack && irq_request |=> stack_push && stack_push_pc == $past(core_pc))
    else $error("return pc not pushed on ack");
  a_entry_flush: assert property (
    stack_push |-> flush_prefetch && !global_irq_enable && !irq_request)
    else $error("entry without flush or with global enable still set");
  a_no_spur_push: assert property (
    !(core_irq_ack && irq_request) |=> !stack_push)
    else $error("push without a taken interrupt");
  a_return_pops: assert property (
    core_return_from_irq && !(core_irq_ack && irq_request)
    |=> stack_pop && ctx_restore && global_irq_enable)
    else $error("return did not pop, restore or set global enable");
  a_no_spur_pop: assert property (
    !core_return_from_irq |=> !stack_pop)
    else $error("pop without a return");
  a_no_spur_rest: assert property (
    !core_return_from_irq |=> !ctx_restore)
    else $error("restore without a return");
  a_gie_gates_req: assert property (
    !global_irq_enable && !avs_write && !core_return_from_irq |=> !irq_request)
    else $error("request while global enable clear");
  // one answer cycle per request, never left low
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule
bind igcs_core igcs_props #(.PC_W(PC_W)) u_props (.clk(clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .core_irq_ack(core_irq_ack), .core_return_from_irq(core_return_from_irq),
  .core_pc(core_pc), .irq_request(irq_request), .flush_prefetch(flush_prefetch),
  .stack_push(stack_push), .stack_push_pc(stack_push_pc), .ctx_restore(ctx_restore),
  .stack_pop(stack_pop), .global_irq_enable(global_irq_enable));
`default_nettype wire

// ===== verification/igcs_core_model.sv
// core model: acks a request after a chosen lag, walks pc and context
`timescale 1ns/10ps
`default_nettype none
module igcs_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // block side
  input  wire logic       irq_request,
  output logic            core_irq_ack,
  output logic            core_return_from_irq,
  output logic [14:0]     core_pc,
  output logic [63:0]     core_context,
  // bench commands
  input  wire logic [1:0] lag,
  input  wire logic       ret_cmd
);
  logic       go;      // request seen, no ack yet
  logic [1:0] wait_q;  // cycles waited on this request
  assign go = irq_request && !core_irq_ack;
  // context moves every cycle, so a capture one cycle off shows up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_pc              <= 15'h0000;
      core_context         <= 64'h0;
      core_irq_ack         <= 1'b0;
      core_return_from_irq <= 1'b0;
      wait_q               <= 2'h0;
    end else begin
      core_pc              <= core_pc + 15'h0001;
      core_context         <= core_context + 64'h0123456789ABCDEF;
      core_return_from_irq <= ret_cmd;
      core_irq_ack         <= go && wait_q == lag;
      wait_q               <= (go && wait_q != lag) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// bench: registers, flags, gating, context entry and return
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] KEEP_N = ~igcs_pkg::STATUS_KEEP_MASK;  // shadowed status bits
  localparam logic [5:0] CTRL = igcs_pkg::ADDR_INT_CTRL;
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, t0 = 1'b0, pin = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0]  pcf = 8'h00, pf1 = 8'h00, pf2 = 8'h00, pf3 = 8'h00, v;
  logic        wreq, ack, ret, irq, push, rest, ret_cmd = 1'b0;
  logic [1:0]  lag = 2'h0;
  logic [14:0] pc;
  logic [63:0] ctx, rest_d, cap, e;
  logic [63:0] exp_q[$];  // expected reads and restores, oldest first
  integer      seed = 32'h2227, miscompares = 0, cmp_count = 0, n, i;
  always #10 clk = ~clk;
  igcs_core u_dut (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .timer0_ovf_evt(t0), .ext_pin(pin), .port_change_flags(pcf), .periph_flags_one(pf1),
    .periph_flags_two(pf2), .periph_flags_three(pf3), .core_irq_ack(ack),
    .core_return_from_irq(ret), .core_pc(pc), .core_context(ctx), .irq_request(irq),
    .flush_prefetch(), .stack_push(push), .stack_push_pc(), .stack_pop(), .ctx_restore(rest),
    .ctx_restore_data(rest_d), .global_irq_enable());
  igcs_core_model u_core (.clk(clk), .rstn(rstn), .irq_request(irq), .core_irq_ack(ack),
    .core_return_from_irq(ret), .core_pc(pc), .core_context(ctx), .lag(lag), .ret_cmd(ret_cmd));
  task automatic cmp(input logic [63:0] g, input logic [63:0] x);
    cmp_count = cmp_count + 1;
    if (g !== x) begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // request held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);  // only the watchdog ends a stalled wait
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] x);
    exp_q.push_back({56'h0, x});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse_t0;
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
  endtask
  task automatic wait_push;
    n = 0;
    while (push !== 1'b1 && n < 40) begin
      @(posedge clk);
      n = n + 1;
    end
    cmp({63'h0, push}, 64'h1);
  endtask
  // return from the routine; the watcher checks the restored context
  task automatic leave;
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    tick(4);
  endtask
  task automatic final_report;
    if (exp_q.size() != 0) miscompares = miscompares + 1;  // answers never seen
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watcher: capture context at a taken ack, compare each answer in order
  always @(posedge clk) begin
    if (ack === 1'b1 && irq === 1'b1) cap <= ctx;
    if ((rd && wreq === 1'b0) || rest === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hX;
      cmp((rest === 1'b1) ? rest_d : {32'h0, rdat}, e);
    end
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i = i + 1) rchk((i < 4) ? 6'(4 * i) : 6'h3C, 8'h00);
    for (i = 1; i < 4; i = i + 1) begin
      v = 8'($random(seed));
      bus(1'b1, 6'(4 * i), v);
      rchk(6'(4 * i), (i == 3) ? (v & igcs_pkg::PEN_THREE_MASK) : v);
      bus(1'b1, 6'(4 * i), 8'h00);
    end
    bus(1'b1, CTRL, 8'h7F);
    rchk(CTRL, 8'h7E);
    cmp({63'h0, irq}, 64'h0);
    bus(1'b1, CTRL, 8'h00);
    // events raise flags with every enable off
    pulse_t0;
    bus(1'b1, igcs_pkg::ADDR_OPTION, 8'h40);
    pin <= 1'b1;
    pcf <= 8'h10;
    tick(6);
    rchk(CTRL, 8'h07);
    rchk(igcs_pkg::ADDR_PIN_CHANGE, 8'h10);
    bus(1'b1, CTRL, 8'h00);
    rchk(CTRL, 8'h01);
    pcf <= 8'h00;
    pin <= 1'b0;
    tick(6);
    rchk(CTRL, 8'h00);
    bus(1'b1, igcs_pkg::ADDR_OPTION, 8'h00);
    pin <= 1'b1;
    tick(6);
    rchk(CTRL, 8'h00);
    pin <= 1'b0;
    tick(6);
    rchk(CTRL, 8'h02);
    bus(1'b1, CTRL, 8'h00);
    // timer0 entry, shadow edit, return
    bus(1'b1, igcs_pkg::ADDR_SHD_STATUS, 8'h00);
    lag <= 2'($random(seed));
    bus(1'b1, CTRL, 8'hA0);
    pulse_t0;
    wait_push;
    for (i = 0; i < 8; i = i + 1) begin
      v = (i == 1) ? (cap[15:8] & KEEP_N) : cap[i*8 +: 8];
      rchk(6'(igcs_pkg::ADDR_SHD_WREG + 4 * i), v);
    end
    rchk(CTRL, 8'h24);
    bus(1'b1, CTRL, 8'h20);
    v = 8'($random(seed));
    bus(1'b1, igcs_pkg::ADDR_SHD_WREG, v);
    exp_q.push_back({cap[63:16], cap[15:8] & KEEP_N, v});
    leave;
    rchk(CTRL, 8'hA0);
    // peripheral source waits for the peripheral enable
    pf1 <= 8'h01;
    bus(1'b1, igcs_pkg::ADDR_PEN_ONE, 8'h01);
    bus(1'b1, CTRL, 8'h80);
    tick(4);
    cmp({63'h0, irq}, 64'h0);
    bus(1'b1, CTRL, 8'hC0);
    wait_push;
    pf1 <= 8'h00;
    exp_q.push_back({cap[63:16], cap[15:8] & KEEP_N, cap[7:0]});
    leave;
    // third register masks its empty bits; the second one requests
    pf3 <= 8'h01;
    bus(1'b1, igcs_pkg::ADDR_PEN_ONE, 8'h00);
    bus(1'b1, igcs_pkg::ADDR_PEN_THREE, 8'hFF);
    tick(4);
    cmp({63'h0, irq}, 64'h0);
    pf2 <= 8'h80;
    bus(1'b1, igcs_pkg::ADDR_PEN_TWO, 8'h80);
    wait_push;
    pf2 <= 8'h00;
    exp_q.push_back({cap[63:16], cap[15:8] & KEEP_N, cap[7:0]});
    leave;
    final_report;
  end
endmodule
`default_nettype wire
